// File: ddr_read_pkg.sv
// Purpose: shared constants and types for the sdram read link
// Assumes: 40 MHz system clock, eight banks, one command per clock
// Notes: times are held in picoseconds and turned into whole clocks
package ddr_read_pkg;
    // clock
    localparam int CLOCK_PERIOD_PS = 25000;

    // link widths
    localparam int BANKS = 8;
    localparam int BANK_W = 3;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 16;
    localparam int AUTO_CLOSE_ADDRESS_BIT = 10;
    localparam int CNT_W = 6;

    // default latencies and burst
    localparam int DEF_ADDITIVE_LATENCY = 1;
    localparam int DEF_COLUMN_ACCESS_LATENCY = 3;
    localparam int DEF_BURST_LENGTH = 4;

    // device times in picoseconds
    localparam int OPEN_TO_COLUMN_DELAY_PS = 20000;
    localparam int SAME_BANK_ROW_CYCLE_TIME_PS = 55000;
    localparam int CROSS_BANK_OPEN_SPACING_PS = 7500;
    localparam int FOUR_OPEN_WINDOW_PS = 37500;
    localparam int READ_TO_CLOSE_TIME_PS = 7500;
    localparam int ROW_CLOSE_TIME_PS = 15000;

    // least time to whole clocks, rounded up, never below one
    function automatic int toCycles(input int ps);
        int c;
        c = (ps + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int RCD_CYC = toCycles(OPEN_TO_COLUMN_DELAY_PS);
    localparam int RC_CYC = toCycles(SAME_BANK_ROW_CYCLE_TIME_PS);
    localparam int RRD_CYC = toCycles(CROSS_BANK_OPEN_SPACING_PS);
    localparam int FAW_CYC = toCycles(FOUR_OPEN_WINDOW_PS);
    localparam int RTP_CYC = toCycles(READ_TO_CLOSE_TIME_PS);
    localparam int RP_CYC = toCycles(ROW_CLOSE_TIME_PS);
    localparam int FAW_SLOTS = 4;

    // link commands
    typedef enum logic [2:0] {
        CMD_NOP = 3'h0,
        CMD_OPEN = 3'h1,
        CMD_READ = 3'h2,
        CMD_WRITE = 3'h3,
        CMD_CLOSE = 3'h4
    } cmd_type;

    // controller registers
    localparam logic [11:0] CMD_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] DATA_OFFSET = 12'h008;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_BANK_LSB = 4;
    localparam int CMD_ADDR_LSB = 8;
    localparam int ST_PENDING = 0;
    localparam int ST_REJECTED = 1;
    localparam int ST_OPEN_LSB = 8;
    localparam int ST_COUNT_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: ddr_link_if.sv
// Purpose: command and read-data link between controller and device
// Assumes: one clock; strobe complement is the inverse of the strobe
// Notes: each data signal carries the rising and falling half of a clock
`timescale 1ns/100ps
interface ddr_link_if;
    ddr_read_pkg::cmd_type cmd;
    logic [ddr_read_pkg::BANK_W-1:0] bank;
    logic [ddr_read_pkg::ADDR_W-1:0] addr;
    logic [ddr_read_pkg::DATA_W-1:0] dqRise;
    logic [ddr_read_pkg::DATA_W-1:0] dqFall;
    logic dqOe;
    logic dqsRise;
    logic dqsFall;
    logic dqsOe;

    modport controller (
        output cmd, bank, addr,
        input dqRise, dqFall, dqOe, dqsRise, dqsFall, dqsOe
    );
    modport device (
        input cmd, bank, addr,
        output dqRise, dqFall, dqOe, dqsRise, dqsFall, dqsOe
    );
endinterface

// File: ddr_read_device.sv
// Purpose: device end: bank rows, read latency, burst and strobe drive
// Assumes: read latency of at least two clocks
// Notes: data is a pattern of bank, row and column, no array is held
`timescale 1ns/100ps
module ddr_read_device #(
    parameter int ADDITIVE_LATENCY = ddr_read_pkg::DEF_ADDITIVE_LATENCY,
    parameter int COLUMN_ACCESS_LATENCY = ddr_read_pkg::DEF_COLUMN_ACCESS_LATENCY,
    parameter int BURST_LENGTH = ddr_read_pkg::DEF_BURST_LENGTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // link
    ddr_link_if.device link,
    // user side status
    output logic misusePulse,
    output logic [ddr_read_pkg::BANKS-1:0] openBanks
);
    localparam int LAT = ADDITIVE_LATENCY + COLUMN_ACCESS_LATENCY;
    localparam logic [2:0] HALF = 3'(BURST_LENGTH / 2);

    logic [ddr_read_pkg::BANKS-1:0] open_reg;
    logic [ddr_read_pkg::ADDR_W-1:0] row_reg [ddr_read_pkg::BANKS];
    logic pipeValid_reg [LAT];
    logic pipeAuto_reg [LAT];
    logic [ddr_read_pkg::BANK_W-1:0] pipeBank_reg [LAT];
    logic [ddr_read_pkg::ADDR_W-1:0] pipeCol_reg [LAT];
    logic [2:0] beats_reg;
    logic burstAuto_reg;
    logic [ddr_read_pkg::BANK_W-1:0] burstBank_reg;
    logic [ddr_read_pkg::ADDR_W-1:0] burstCol_reg;
    logic isOpen;
    logic readOk;
    logic start;
    logic autoDone;
    logic [ddr_read_pkg::ADDR_W-1:0] nextCol;

    // pattern word for one element
    function automatic logic [ddr_read_pkg::DATA_W-1:0] element(
        input logic [ddr_read_pkg::BANK_W-1:0] b,
        input logic [ddr_read_pkg::ADDR_W-1:0] row,
        input logic [ddr_read_pkg::ADDR_W-1:0] col
    );
        return {b, row[4:0], col[7:0]};
    endfunction

    // command decode
    assign isOpen = open_reg[link.bank];
    assign readOk = (link.cmd == ddr_read_pkg::CMD_READ) && isOpen;
    assign start = pipeValid_reg[LAT-1];
    assign nextCol = burstCol_reg + 14'h0002;
    assign autoDone = (beats_reg == 3'h1) && burstAuto_reg && !start;
    assign openBanks = open_reg;

    // misuse of bank state flagged for one clock
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            misusePulse <= 1'b0;
        end else begin
            misusePulse <= ((link.cmd == ddr_read_pkg::CMD_OPEN) && isOpen)
                || (((link.cmd == ddr_read_pkg::CMD_READ)
                || (link.cmd == ddr_read_pkg::CMD_WRITE)) && !isOpen);
        end
    end

    // open bank takes bank and row from the open command
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            open_reg <= '0;
            for (int i = 0; i < ddr_read_pkg::BANKS; i++) begin
                row_reg[i] <= '0;
            end
        end else begin
            if (autoDone) begin
                open_reg[burstBank_reg] <= 1'b0;
            end
            if ((link.cmd == ddr_read_pkg::CMD_OPEN) && !isOpen) begin
                open_reg[link.bank] <= 1'b1;
                row_reg[link.bank] <= link.addr;
            end else if (link.cmd == ddr_read_pkg::CMD_CLOSE) begin
                if (link.addr[ddr_read_pkg::AUTO_CLOSE_ADDRESS_BIT]) begin
                    open_reg <= '0;
                end else begin
                    open_reg[link.bank] <= 1'b0;
                end
            end
        end
    end

    // read latency delay line
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < LAT; i++) begin
                pipeValid_reg[i] <= 1'b0;
                pipeAuto_reg[i] <= 1'b0;
                pipeBank_reg[i] <= '0;
                pipeCol_reg[i] <= '0;
            end
        end else begin
            pipeValid_reg[0] <= readOk;
            pipeAuto_reg[0] <= link.addr[ddr_read_pkg::AUTO_CLOSE_ADDRESS_BIT];
            pipeBank_reg[0] <= link.bank;
            pipeCol_reg[0] <= link.addr;
            for (int i = 1; i < LAT; i++) begin
                pipeValid_reg[i] <= pipeValid_reg[i-1];
                pipeAuto_reg[i] <= pipeAuto_reg[i-1];
                pipeBank_reg[i] <= pipeBank_reg[i-1];
                pipeCol_reg[i] <= pipeCol_reg[i-1];
            end
        end
    end

    // burst state; a new start replaces a running burst
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            beats_reg <= 3'h0;
            burstAuto_reg <= 1'b0;
            burstBank_reg <= '0;
            burstCol_reg <= '0;
        end else if (start) begin
            beats_reg <= HALF;
            burstAuto_reg <= pipeAuto_reg[LAT-1];
            burstBank_reg <= pipeBank_reg[LAT-1];
            burstCol_reg <= pipeCol_reg[LAT-1];
        end else if (beats_reg != 3'h0) begin
            beats_reg <= beats_reg - 3'h1;
            burstCol_reg <= nextCol;
        end
    end

    // data and strobe drive, two elements per clock
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            link.dqOe <= 1'b0;
            link.dqRise <= '0;
            link.dqFall <= '0;
            link.dqsOe <= 1'b0;
            link.dqsRise <= 1'b0;
            link.dqsFall <= 1'b0;
        end else if (start || (beats_reg > 3'h1)) begin
            link.dqOe <= 1'b1;
            link.dqsOe <= 1'b1;
            link.dqsRise <= 1'b1;
            link.dqsFall <= 1'b0;
            if (start) begin
                link.dqRise <= element(pipeBank_reg[LAT-1],
                    row_reg[pipeBank_reg[LAT-1]], pipeCol_reg[LAT-1]);
                link.dqFall <= element(pipeBank_reg[LAT-1],
                    row_reg[pipeBank_reg[LAT-1]], pipeCol_reg[LAT-1] + 14'h0001);
            end else begin
                link.dqRise <= element(burstBank_reg, row_reg[burstBank_reg], nextCol);
                link.dqFall <= element(burstBank_reg, row_reg[burstBank_reg],
                    nextCol + 14'h0001);
            end
        end else if (pipeValid_reg[LAT-2]) begin
            link.dqOe <= 1'b0;
            link.dqsOe <= 1'b1;
            link.dqsRise <= 1'b0;
            link.dqsFall <= 1'b0;
        end else begin
            link.dqOe <= 1'b0;
            link.dqsOe <= 1'b0;
            link.dqsRise <= 1'b0;
            link.dqsFall <= 1'b0;
        end
    end
endmodule

// File: ddr_read_controller.sv
// Purpose: controller end: spaces commands to meet bank and read timing
// Assumes: software writes one command at a time over axi4-lite
// Notes: never truncates a burst; reads follow each other at half a burst
`timescale 1ns/100ps
// Behaviour
// - open a row before reading or writing
// - open command carries bank and row
// - wait open-to-column delay before column access
// - same bank reopen only after close, row cycle
// - cross bank opens spaced by open spacing
// - at most four opens per window
// - read carries column, bank, auto close bit
// - auto close shuts row after burst (the device leaves the row open if the next burst starts before it is shut)
// - first element read latency after read
// - one element per clock half
// - strobe preamble and postamble around data (the device drives the preamble only, strobe is released with no postamble)
// - data pins released after last burst
// - length four bursts never interrupted
// - length eight truncated only by read
// - interrupting read exactly two clocks later
// - read data finishes before any write
// - explicit close needs read-to-close spacing (a close of all banks checks the named bank only)
// - read-to-close measured from last prefetch
// - read-to-close spacing formula with two floor
// - no bank command before row close time
module ddr_read_controller #(
    parameter int ADDITIVE_LATENCY = ddr_read_pkg::DEF_ADDITIVE_LATENCY,
    parameter int COLUMN_ACCESS_LATENCY = ddr_read_pkg::DEF_COLUMN_ACCESS_LATENCY,
    parameter int BURST_LENGTH = ddr_read_pkg::DEF_BURST_LENGTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // axi4-lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [11:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [11:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // link
    ddr_link_if.controller link
);
    localparam int CW = ddr_read_pkg::CNT_W;
    localparam int NB = ddr_read_pkg::BANKS;
    localparam int HALF = BURST_LENGTH / 2;
    localparam int RTP_EFF = (ddr_read_pkg::RTP_CYC > 2) ? ddr_read_pkg::RTP_CYC : 2;
    localparam int RD_TO_CLOSE = ADDITIVE_LATENCY + HALF - 2 + RTP_EFF;
    // spacing n becomes a load of n - 1
    localparam logic [CW-1:0] RCD_LOAD = CW'(ddr_read_pkg::RCD_CYC - 1);
    localparam logic [CW-1:0] RC_LOAD = CW'(ddr_read_pkg::RC_CYC - 1);
    localparam logic [CW-1:0] RRD_LOAD = CW'(ddr_read_pkg::RRD_CYC - 1);
    localparam logic [CW-1:0] FAW_LOAD = CW'(ddr_read_pkg::FAW_CYC - 1);
    localparam logic [CW-1:0] RP_LOAD = CW'(ddr_read_pkg::RP_CYC - 1);
    localparam logic [CW-1:0] RTP_LOAD = CW'(RD_TO_CLOSE - 1);
    localparam logic [CW-1:0] AUTO_LOAD = CW'(RD_TO_CLOSE + ddr_read_pkg::RP_CYC - 1);
    localparam logic [CW-1:0] GAP_LOAD = CW'(HALF - 1);
    localparam logic [CW-1:0] RD_WR_LOAD = CW'(HALF + 1);

    logic awHeld_reg;
    logic wHeld_reg;
    logic [11:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic pending_reg;
    logic rejected_reg;
    ddr_read_pkg::cmd_type op_reg;
    logic [ddr_read_pkg::BANK_W-1:0] bank_reg;
    logic [ddr_read_pkg::ADDR_W-1:0] addr_reg;
    logic [NB-1:0] open_reg;
    logic [CW-1:0] rcd_reg [NB];
    logic [CW-1:0] rc_reg [NB];
    logic [CW-1:0] rp_reg [NB];
    logic [CW-1:0] rtp_reg [NB];
    logic [CW-1:0] faw_reg [ddr_read_pkg::FAW_SLOTS];
    logic [CW-1:0] rrd_reg;
    logic [CW-1:0] gap_reg;
    logic [CW-1:0] rdWr_reg;
    logic [31:0] lastData_reg;
    logic [15:0] count_reg;
    logic doWrite;
    logic cmdWrite;
    logic badCmd;
    logic legal;
    logic issue;
    logic fawFree;
    logic [1:0] fawSel;
    logic closeAll;
    ddr_read_pkg::cmd_type newOp;
    logic [ddr_read_pkg::BANK_W-1:0] newBank;

    // count down to zero and stay there
    function automatic logic [CW-1:0] dec(input logic [CW-1:0] x);
        return (x == '0) ? '0 : x - 1'b1;
    endfunction

    // axi handshakes
    assign awready = !awHeld_reg && !bvalid;
    assign wready = !wHeld_reg && !bvalid;
    assign arready = !rvalid;
    assign doWrite = awHeld_reg && wHeld_reg && !bvalid;
    assign cmdWrite = doWrite && (awAddr_reg == ddr_read_pkg::CMD_OFFSET)
        && (wStrb_reg == 4'hf);
    assign newOp = ddr_read_pkg::cmd_type'(wData_reg[ddr_read_pkg::CMD_OP_LSB +: 3]);
    assign newBank = wData_reg[ddr_read_pkg::CMD_BANK_LSB +: ddr_read_pkg::BANK_W];

    // misuse of bank state is refused at the register
    assign badCmd = pending_reg
        || ((newOp == ddr_read_pkg::CMD_OPEN) && open_reg[newBank])
        || (((newOp == ddr_read_pkg::CMD_READ) || (newOp == ddr_read_pkg::CMD_WRITE))
        && !open_reg[newBank]);

    // write address and data capture, then response
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= '0;
            wData_reg <= '0;
            wStrb_reg <= '0;
            bvalid <= 1'b0;
            bresp <= ddr_read_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld_reg <= 1'b1;
                wData_reg <= wdata;
                wStrb_reg <= wstrb;
            end
            if (doWrite) begin
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (awAddr_reg == ddr_read_pkg::CMD_OFFSET)
                    ? ddr_read_pkg::RESP_OKAY : ddr_read_pkg::RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read response
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= ddr_read_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= ddr_read_pkg::RESP_OKAY;
            case (araddr)
                ddr_read_pkg::STATUS_OFFSET: begin
                    rdata <= {count_reg, open_reg, 6'h00, rejected_reg, pending_reg};
                end
                ddr_read_pkg::DATA_OFFSET: begin
                    rdata <= lastData_reg;
                end
                default: begin
                    rdata <= '0;
                    rresp <= ddr_read_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // held command and refusal flag
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pending_reg <= 1'b0;
            rejected_reg <= 1'b0;
            op_reg <= ddr_read_pkg::CMD_NOP;
            bank_reg <= '0;
            addr_reg <= '0;
        end else if (cmdWrite) begin
            rejected_reg <= badCmd;
            if (!badCmd) begin
                pending_reg <= 1'b1;
                op_reg <= newOp;
                bank_reg <= newBank;
                addr_reg <= wData_reg[ddr_read_pkg::CMD_ADDR_LSB +: ddr_read_pkg::ADDR_W];
            end
        end else if (issue) begin
            pending_reg <= 1'b0;
        end
    end

    // first free slot of the four-open window
    always_comb begin
        fawFree = 1'b0;
        fawSel = 2'h0;
        for (int i = ddr_read_pkg::FAW_SLOTS - 1; i >= 0; i--) begin
            if (faw_reg[i] == '0) begin
                fawFree = 1'b1;
                fawSel = 2'(i);
            end
        end
    end

    // timing check for the held command
    always_comb begin
        case (op_reg)
            ddr_read_pkg::CMD_OPEN: begin
                legal = (rc_reg[bank_reg] == '0) && (rrd_reg == '0) && fawFree;
            end
            ddr_read_pkg::CMD_READ: begin
                legal = (rcd_reg[bank_reg] == '0) && (gap_reg == '0);
            end
            ddr_read_pkg::CMD_WRITE: begin
                legal = (rcd_reg[bank_reg] == '0) && (gap_reg == '0)
                    && (rdWr_reg == '0);
            end
            ddr_read_pkg::CMD_CLOSE: begin
                legal = (rtp_reg[bank_reg] == '0);
            end
            default: begin
                legal = 1'b1;
            end
        endcase
        legal = legal && (rp_reg[bank_reg] == '0);
    end

    assign issue = pending_reg && legal;
    assign closeAll = addr_reg[ddr_read_pkg::AUTO_CLOSE_ADDRESS_BIT];

    // command onto the link, one clock each
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            link.cmd <= ddr_read_pkg::CMD_NOP;
            link.bank <= '0;
            link.addr <= '0;
        end else begin
            link.cmd <= issue ? op_reg : ddr_read_pkg::CMD_NOP;
            link.bank <= bank_reg;
            link.addr <= addr_reg;
        end
    end

    // spacing counters shared by all banks
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rrd_reg <= '0;
            gap_reg <= '0;
            rdWr_reg <= '0;
            for (int i = 0; i < ddr_read_pkg::FAW_SLOTS; i++) begin
                faw_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < ddr_read_pkg::FAW_SLOTS; i++) begin
                faw_reg[i] <= dec(faw_reg[i]);
            end
            rrd_reg <= dec(rrd_reg);
            gap_reg <= dec(gap_reg);
            rdWr_reg <= dec(rdWr_reg);
            if (issue && (op_reg == ddr_read_pkg::CMD_OPEN)) begin
                rrd_reg <= RRD_LOAD;
                faw_reg[fawSel] <= FAW_LOAD;
            end
            if (issue && ((op_reg == ddr_read_pkg::CMD_READ)
                || (op_reg == ddr_read_pkg::CMD_WRITE))) begin
                gap_reg <= GAP_LOAD;
            end
            if (issue && (op_reg == ddr_read_pkg::CMD_READ)) begin
                rdWr_reg <= RD_WR_LOAD;
            end
        end
    end

    // per-bank state and counters
    for (genvar b = 0; b < NB; b++) begin : g_bank
        logic hit;
        assign hit = issue && (bank_reg == b);
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                open_reg[b] <= 1'b0;
                rcd_reg[b] <= '0;
                rc_reg[b] <= '0;
                rp_reg[b] <= '0;
                rtp_reg[b] <= '0;
            end else begin
                rcd_reg[b] <= dec(rcd_reg[b]);
                rc_reg[b] <= dec(rc_reg[b]);
                rp_reg[b] <= dec(rp_reg[b]);
                rtp_reg[b] <= dec(rtp_reg[b]);
                if (hit && (op_reg == ddr_read_pkg::CMD_OPEN)) begin
                    open_reg[b] <= 1'b1;
                    rcd_reg[b] <= RCD_LOAD;
                    rc_reg[b] <= RC_LOAD;
                end
                if (hit && (op_reg == ddr_read_pkg::CMD_READ)) begin
                    rtp_reg[b] <= RTP_LOAD;
                    if (closeAll) begin
                        open_reg[b] <= 1'b0;
                        rp_reg[b] <= AUTO_LOAD;
                    end
                end
                if (hit && (op_reg == ddr_read_pkg::CMD_WRITE) && closeAll) begin
                    open_reg[b] <= 1'b0;
                    rp_reg[b] <= AUTO_LOAD;
                end
                if (issue && (op_reg == ddr_read_pkg::CMD_CLOSE)
                    && ((bank_reg == b) || closeAll)) begin
                    open_reg[b] <= 1'b0;
                    rp_reg[b] <= RP_LOAD;
                end
            end
        end
    end

    // capture of returned read data
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lastData_reg <= '0;
            count_reg <= '0;
        end else if (link.dqOe) begin
            lastData_reg <= {link.dqFall, link.dqRise};
            count_reg <= count_reg + 16'h0002;
        end
    end
endmodule

// File: ddr_link_assertions.sv
// Purpose: timing checks on the read link
// Assumes: latencies 1 and 3, burst of four, at 40 MHz
// Notes: sees link signals only
`timescale 1ns/100ps
module ddr_link_assertions (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // link
    input ddr_read_pkg::cmd_type cmd,
    input wire logic [2:0] bank,
    input wire logic [13:0] addr,
    input wire logic [15:0] dqRise,
    input wire logic [15:0] dqFall,
    input wire logic dqOe,
    input wire logic dqsRise,
    input wire logic dqsFall,
    input wire logic dqsOe
);
    logic rd, op, shut;
    // command decode
    assign rd = cmd == ddr_read_pkg::CMD_READ;
    assign op = cmd == ddr_read_pkg::CMD_OPEN;
    assign shut = cmd == ddr_read_pkg::CMD_CLOSE;
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    a_first_data: assert property (rd |-> ##5 dqOe)
        else $error("late data");
    a_data_pattern: assert property (rd |-> ##5 (dqRise[15:13] == $past(bank, 5)
        && dqRise[7:0] == $past(addr[7:0], 5) && dqFall[7:0] == $past(addr[7:0], 5) + 8'h01))
        else $error("bad data");
    a_read_preamble: assert property (rd && !$past(rd, 2) |->
        ##4 (dqsOe && !dqsRise && !dqsFall && !dqOe)) else $error("no preamble");
    a_data_strobe: assert property (dqOe |-> dqsOe && dqsRise && !dqsFall)
        else $error("bad strobe");
    a_read_spacing: assert property (rd |=> !rd)
        else $error("read too soon");
    a_write_after_read: assert property (rd |=> (cmd != ddr_read_pkg::CMD_WRITE) [*3])
        else $error("write too soon");
    a_close_after_read: assert property (rd |=> !(shut && (bank == $past(bank) || addr[10]))
        ##1 !(shut && (bank == $past(bank, 2) || addr[10]))) else $error("close too soon");
    a_reopen_spacing: assert property (op |=> !(op && bank == $past(bank))
        ##1 !(op && bank == $past(bank, 2))) else $error("reopen too soon");
endmodule

// File: sdram_activate_read_timing_tb.sv
// Purpose: end to end bench of the read link
// Assumes: default latencies, 40 MHz clock
// Notes: commands go in over axi4-lite
`timescale 1ns/100ps
module sdram_activate_read_timing_tb;
    logic clock = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, misusePulse;
    logic misuseSeen = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0] wstrb = 0;
    logic [1:0] bresp, rresp, r;
    logic [7:0] openBanks;
    int nErrors = 0, checksDone = 0, cycles = 0;
    ddr_link_if link ();
    // clock
    always #12.5 clock = ~clock;
    // both ends and the checker
    ddr_read_controller ddr_read_controller_inst (.clock(clock), .rst(rst), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .link(link));
    ddr_read_device ddr_read_device_inst (.clock(clock), .rst(rst), .link(link),
        .misusePulse(misusePulse), .openBanks(openBanks));
    ddr_link_assertions ddr_link_assertions_inst (.clock(clock), .rst(rst), .cmd(link.cmd),
        .bank(link.bank), .addr(link.addr), .dqRise(link.dqRise), .dqFall(link.dqFall),
        .dqOe(link.dqOe), .dqsRise(link.dqsRise), .dqsFall(link.dqsFall), .dqsOe(link.dqsOe));
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        checksDone++;
        if (s !== e) begin
            nErrors++;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic conclude();
        if (nErrors == 0 && checksDone > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one axi4-lite write or read, held until answered
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v,
        input logic [3:0] s);
        logic ta, tw, tr, seen;
        @(posedge clock);
        {awaddr, araddr, wdata, wstrb} <= {a, a, v, s};
        {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
        do begin
            @(negedge clock);
            {ta, tw, tr} = {awvalid && awready, wvalid && wready, arvalid && arready};
            seen = bvalid || rvalid;
            r = w ? bresp : rresp;
            d = rdata;
            @(posedge clock);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
            if (tr) arvalid <= 1'h0;
        end while (seen !== 1'h1);
        {bready, rready} <= 2'h0;
    endtask
    // command word, then wait until issued and burst drained
    task automatic cmdw(input logic [2:0] o, input logic [2:0] b, input logic [13:0] a,
        input logic [3:0] s);
        xfer(1'h1, ddr_read_pkg::CMD_OFFSET, {10'h0, a, 1'h0, b, 1'h0, o}, s);
        do xfer(1'h0, ddr_read_pkg::STATUS_OFFSET, 32'h0, 4'h0); while (d[0] !== 1'h0);
        repeat (8) @(posedge clock);
    endtask
    task automatic st(input logic [31:0] e);
        xfer(1'h0, ddr_read_pkg::STATUS_OFFSET, 32'h0, 4'h0);
        check(d, e);
    endtask
    // hang guard
    always @(posedge clock) begin
        cycles++;
        if (misusePulse === 1'h1) misuseSeen = 1'h1;
        if (cycles > 20000) begin
            nErrors++;
            conclude();
        end
    end
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'h0;
        st(32'h0000_0000);
        cmdw(3'h1, 3'h2, 14'h0005, 4'hf);
        st(32'h0000_0400);
        check({24'h0, openBanks}, 32'h0000_0004);
        cmdw(3'h1, 3'h2, 14'h0005, 4'hf);
        st(32'h0000_0402);
        cmdw(3'h2, 3'h2, 14'h0010, 4'hf);
        st(32'h0004_0400);
        xfer(1'h0, ddr_read_pkg::DATA_OFFSET, 32'h0, 4'h0);
        check(d, 32'h4513_4512);
        cmdw(3'h2, 3'h2, 14'h0420, 4'hf);
        st(32'h0008_0000);
        check({24'h0, openBanks}, 32'h0000_0000);
        cmdw(3'h1, 3'h5, 14'h0001, 4'h3);
        st(32'h0008_0000);
        cmdw(3'h2, 3'h2, 14'h0000, 4'hf);
        st(32'h0008_0002);
        for (int i = 1; i <= 4; i++) cmdw(3'(i), 3'h3, 14'h0001, 4'hf);
        st(32'h000c_0000);
        xfer(1'h1, ddr_read_pkg::DATA_OFFSET, 32'h0, 4'hf);
        check({30'h0, r}, {30'h0, ddr_read_pkg::RESP_SLVERR});
        xfer(1'h0, ddr_read_pkg::CMD_OFFSET, 32'h0, 4'h0);
        check({d[31:2], r}, {30'h0, ddr_read_pkg::RESP_SLVERR});
        check({31'h0, misuseSeen}, 32'h0);
        conclude();
    end
endmodule
